// File: condition_eval.v
// Condition flag evaluation for test and compare operations
`timescale 1ns/10ps
module condition_eval (
  first,
  second,
  flags
);
  input wire [31:0] first;
  input wire [31:0] second;
  output reg [7:0] flags;
`include "data_register_map.vh"

  always @* begin
    flags = 8'h00;
    flags[`CB_NONZERO] = (first != 32'h00000000);
    flags[`CB_ZERO] = (first == 32'h00000000);
    flags[`CB_POS] = ~first[31] & (first != 32'h00000000);
    flags[`CB_NEG] = first[31];
    // Signed so a negative first is less than a positive second
    flags[`CB_GREATER] = ($signed(first) > $signed(second));
    flags[`CB_LESS] = ($signed(first) < $signed(second));
    flags[`CB_EQUAL] = (first == second);
    flags[`CB_UNEQUAL] = (first != second);
  end
endmodule // condition_eval

// File: data_register_map.vh
// Constants of the data-register math and condition unit
`ifndef DATA_REGISTER_MAP_VH
`define DATA_REGISTER_MAP_VH

// Command operation codes
`define OP_W 4
`define OP_LOAD 4'h0
`define OP_READ 4'h1
`define OP_ADD 4'h2
`define OP_SUB 4'h3
`define OP_MUL 4'h4
`define OP_DIV 4'h5
`define OP_AND 4'h6
`define OP_OR 4'h7
`define OP_TEST_IMM 4'h8
`define OP_COMPARE 4'h9
`define OP_JUMP 4'ha
`define OP_ENC_SET 4'hb
`define OP_ANA_OFS 4'hc

// Register indices (numeric assignment)
`define SEL_W 10
`define IDX_ACCUM 10'h000
`define IDX_ANALOG 10'h031
`define IDX_LINE 10'h032
`define IDX_CURRENT 10'h033
`define IDX_DISTANCE 10'h034
`define IDX_ENCODER 10'h035
`define IDX_FAULT 10'h036
`define IDX_SENSOR 10'h037
`define IDX_CONDITION 10'h038
`define IDX_INPUTS 10'h039
// Character code minus this gives the numeric index
`define CHAR_BASE 10'h030

// Condition word bit positions
`define CB_NONZERO 0
`define CB_ZERO 1
`define CB_POS 2
`define CB_NEG 3
`define CB_GREATER 4
`define CB_LESS 5
`define CB_EQUAL 6
`define CB_UNEQUAL 7

// Analog scaling: full-scale count
`define ANALOG_FULL 17'h07ff8

// Reset values
`define RST_WORD 32'h00000000
`define RST_HALF 16'h0000

`endif

// File: data_register_math_condition_unit.v
// Data-register file with math, condition testing and status registers
`timescale 1ns/10ps
// Notes on behaviour
// - Math and logic results go to accumulator
// - One operation per accepted command
// - Integer only; multiply and divide 16-bit
// - Add, subtract, multiply, divide, AND, OR
// - Test compares register against immediate
// - Compare checks register against register
// - Test or compare replaces condition word
// - Condition bits: nonzero..unequal, bits 0-7
// - Greater/less by signed first versus second
// - Condition word readable and drives jump
// - Registers short or long; math respects width
// - Select register by character or number
// - Encoder set with zero clears position
// - Sensor register captures position on hit
// - Absolute position is zero after reset
// - Distance live or at move end
// - Input pattern: index, inputs, outputs, unused
// - Input 1 means open; output 1 closed
// - Analog count 32760 means +10V
// - Writes to read-only registers silently ignored
module data_register_math_condition_unit #(
  parameter USER_REGS = 10,
  parameter [9:0] USER_LONG_MASK = 10'h3ff,
  parameter LIVE_DISTANCE = 1
) (
  ref_clk,
  rst_n,
  cmd_valid,
  cmd_op,
  cmd_sel_a,
  cmd_sel_a_numeric,
  cmd_sel_b,
  cmd_sel_b_numeric,
  cmd_data,
  adc_code,
  queue_line,
  current_cmd,
  fault_code,
  motor_step,
  motor_dir,
  move_start,
  move_end,
  encoder_step,
  encoder_dir,
  sensor_hit,
  index_closed,
  input_closed,
  output_closed,
  rsp_valid,
  rsp_data,
  jump_valid,
  jump_taken,
  condition_out
);
`include "data_register_map.vh"
  input wire ref_clk;
  input wire rst_n;
  input wire cmd_valid;
  input wire [3:0] cmd_op;
  input wire [9:0] cmd_sel_a;
  input wire cmd_sel_a_numeric;
  input wire [9:0] cmd_sel_b;
  input wire cmd_sel_b_numeric;
  input wire [31:0] cmd_data;
  input wire [15:0] adc_code;
  input wire [15:0] queue_line;
  input wire [15:0] current_cmd;
  input wire [31:0] fault_code;
  input wire motor_step;
  input wire motor_dir;
  input wire move_start;
  input wire move_end;
  input wire encoder_step;
  input wire encoder_dir;
  input wire sensor_hit;
  input wire index_closed;
  input wire [6:0] input_closed;
  input wire [2:0] output_closed;
  output reg rsp_valid;
  output reg [31:0] rsp_data;
  output reg jump_valid;
  output reg jump_taken;
  output reg [7:0] condition_out;

  ////////////////////////////////////////////////////////////////////////
  // State
  reg [31:0] user_reg [0:USER_REGS-1];
  reg [15:0] condition_reg;
  reg [31:0] abs_pos_reg;
  reg [31:0] encoder_reg;
  reg [31:0] distance_reg;
  reg [31:0] move_base_reg;
  reg moving_reg;
  reg [15:0] sensor_reg;
  reg [15:0] analog_ofs_reg;
  reg [15:0] analog_reg;
  reg [15:0] line_reg;
  reg [15:0] current_reg;
  reg [31:0] fault_reg;
  reg [15:0] pattern_reg;
  integer k;

  ////////////////////////////////////////////////////////////////////////
  // Register selection and typed fetch

  // Character form is the numeric form offset by the digit base
  function [9:0] sel_index;
    input [9:0] sel;
    input numeric;
    begin
      sel_index = numeric ? sel : sel - `CHAR_BASE;
    end
  endfunction

  function is_long;
    input [9:0] idx;
    begin
      if (idx < USER_REGS)
        is_long = USER_LONG_MASK[idx[3:0]];
      else
        is_long = (idx == `IDX_DISTANCE) || (idx == `IDX_ENCODER) ||
          (idx == `IDX_FAULT);
    end
  endfunction

  // Short registers are sign-extended so math sees their true value
  function [31:0] fit;
    input [31:0] v;
    input long_w;
    begin
      fit = long_w ? v : {{16{v[15]}}, v[15:0]};
    end
  endfunction

  // Reads only its arguments; status slices follow the packing of
  // status_bus below
  function [31:0] fetch;
    input [9:0] idx;
    input [31:0] user_val;
    input [191:0] status;
    begin
      fetch = 32'h00000000;
      if (idx < USER_REGS)
        fetch = user_val;
      else begin
        case (idx)
          `IDX_ANALOG: fetch = {16'h0000, status[15:0]};
          `IDX_LINE: fetch = {16'h0000, status[31:16]};
          `IDX_CURRENT: fetch = {16'h0000, status[47:32]};
          `IDX_DISTANCE: fetch = status[79:48];
          `IDX_ENCODER: fetch = status[111:80];
          `IDX_FAULT: fetch = status[143:112];
          `IDX_SENSOR: fetch = {16'h0000, status[159:144]};
          `IDX_CONDITION: fetch = {16'h0000, status[175:160]};
          `IDX_INPUTS: fetch = {16'h0000, status[191:176]};
          default: fetch = 32'h00000000;
        endcase
      end
      fetch = fit(fetch, is_long(idx));
    end
  endfunction

  wire [9:0] idx_a;
  wire [9:0] idx_b;
  wire [31:0] user_a;
  wire [31:0] user_b;
  wire [191:0] status_bus;
  wire [31:0] val_a;
  wire [31:0] val_b;
  wire [31:0] imm_b;
  wire a_user;
  wire acc_long;

  assign idx_a = sel_index(cmd_sel_a, cmd_sel_a_numeric);
  assign idx_b = sel_index(cmd_sel_b, cmd_sel_b_numeric);
  // Slots past the user file read as zero rather than unknown
  assign user_a = (idx_a < USER_REGS) ? user_reg[idx_a[3:0]] : `RST_WORD;
  assign user_b = (idx_b < USER_REGS) ? user_reg[idx_b[3:0]] : `RST_WORD;

  // Every readable register reaches fetch as an argument, so these
  // assignments follow the registers and not only the selects
  assign status_bus = {pattern_reg, condition_reg, sensor_reg, fault_reg,
    encoder_reg, distance_reg, current_reg, line_reg, analog_reg};
  assign val_a = fetch(idx_a, user_a, status_bus);
  assign val_b = fetch(idx_b, user_b, status_bus);
  assign imm_b = fit(cmd_data, is_long(idx_a));
  assign a_user = (idx_a < USER_REGS);
  assign acc_long = is_long(`IDX_ACCUM);

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic and comparison

  wire [31:0] math_result;
  wire math_ok;
  wire [7:0] test_flags;
  wire [7:0] cmp_flags;

  math_unit u_math (
    .op(cmd_op),
    .a(val_a),
    .b(val_b),
    .result(math_result),
    .valid(math_ok)
  );

  condition_eval u_test (
    .first(val_a),
    .second(imm_b),
    .flags(test_flags)
  );

  condition_eval u_cmp (
    .first(val_a),
    .second(val_b),
    .flags(cmp_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status sampling

  wire signed [32:0] analog_prod;
  wire [15:0] analog_scaled;

  // Full-scale code -32768 lands on -32760; the last 8 counts are lost
  assign analog_prod = $signed(adc_code) * $signed(`ANALOG_FULL);
  assign analog_scaled = analog_prod[30:15];

  // Status levels are registered once so every read sees one sample
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_reg <= `RST_HALF;
      line_reg <= `RST_HALF;
      current_reg <= `RST_HALF;
      fault_reg <= `RST_WORD;
      pattern_reg <= `RST_HALF;
    end else begin
      analog_reg <= analog_scaled - analog_ofs_reg;
      line_reg <= queue_line;
      current_reg <= current_cmd;
      fault_reg <= fault_code;
      pattern_reg <= {5'h00, output_closed, ~input_closed,
        ~index_closed};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Position tracking

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      abs_pos_reg <= `RST_WORD;
      encoder_reg <= `RST_WORD;
      sensor_reg <= `RST_HALF;
      distance_reg <= `RST_WORD;
      move_base_reg <= `RST_WORD;
      moving_reg <= 1'b0;
    end else begin
      // Only reset clears the step count; no command writes it
      if (motor_step)
        abs_pos_reg <= motor_dir ? abs_pos_reg - 32'h00000001 :
          abs_pos_reg + 32'h00000001;
      // A host set wins over a same-cycle encoder count
      if (cmd_valid && cmd_op == `OP_ENC_SET)
        encoder_reg <= cmd_data;
      else if (encoder_step)
        encoder_reg <= encoder_dir ? encoder_reg - 32'h00000001 :
          encoder_reg + 32'h00000001;
      if (sensor_hit)
        sensor_reg <= abs_pos_reg[15:0];
      if (move_start) begin
        move_base_reg <= abs_pos_reg;
        moving_reg <= 1'b1;
        if (LIVE_DISTANCE)
          distance_reg <= `RST_WORD;
      end else if (move_end) begin
        moving_reg <= 1'b0;
        distance_reg <= abs_pos_reg - move_base_reg;
      end else if (moving_reg && LIVE_DISTANCE)
        distance_reg <= abs_pos_reg - move_base_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command execution

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < USER_REGS; k = k + 1)
        user_reg[k] <= `RST_WORD;
      condition_reg <= `RST_HALF;
      analog_ofs_reg <= `RST_HALF;
      rsp_valid <= 1'b0;
      rsp_data <= `RST_WORD;
      jump_valid <= 1'b0;
      jump_taken <= 1'b0;
      condition_out <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      jump_valid <= 1'b0;
      condition_out <= condition_reg[7:0];
      // Each accepted command performs one operation only
      if (cmd_valid) begin
        rsp_valid <= 1'b1;
        rsp_data <= `RST_WORD;
        case (cmd_op)
          `OP_LOAD: begin
            // Read-only and unmapped targets drop the write quietly
            if (a_user)
              user_reg[idx_a[3:0]] <= fit(cmd_data,
                is_long(idx_a));
          end
          `OP_READ: rsp_data <= val_a;
          `OP_ADD, `OP_SUB, `OP_MUL, `OP_DIV, `OP_AND, `OP_OR: begin
            if (math_ok) begin
              user_reg[0] <= fit(math_result, acc_long);
              rsp_data <= fit(math_result, acc_long);
            end else
              rsp_data <= user_reg[0];
          end
          `OP_TEST_IMM: begin
            condition_reg <= {8'h00, test_flags};
            rsp_data <= {24'h000000, test_flags};
          end
          `OP_COMPARE: begin
            condition_reg <= {8'h00, cmp_flags};
            rsp_data <= {24'h000000, cmp_flags};
          end
          `OP_JUMP: begin
            jump_valid <= 1'b1;
            jump_taken <= |(condition_reg[7:0] & cmd_data[7:0]);
          end
          `OP_ENC_SET: rsp_data <= cmd_data;
          `OP_ANA_OFS: analog_ofs_reg <= cmd_data[15:0];
          default: rsp_data <= `RST_WORD;
        endcase
      end
    end
  end

endmodule // data_register_math_condition_unit

// File: data_register_math_condition_unit_tb.sv
// Self-checking bench for the math and condition unit
`timescale 1ns/10ps
`include "data_register_map.vh"
bind data_register_math_condition_unit unit_props chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_sel_a(cmd_sel_a), .cmd_data(cmd_data),
  .cmd_sel_a_numeric(cmd_sel_a_numeric), .encoder_step(encoder_step),
  .index_closed(index_closed), .input_closed(input_closed),
  .output_closed(output_closed), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .jump_valid(jump_valid), .jump_taken(jump_taken),
  .condition_out(condition_out));
module data_register_math_condition_unit_tb;
  localparam [10:0] R1 = 11'h031;
  localparam [10:0] R2N = 11'h402;
  localparam [10:0] ACC = 11'h030;
  reg ref_clk, rst_n, ok, index_closed;
  reg motor_step, move_start, move_end, encoder_step, sensor_hit;
  reg [15:0] adc_code, current_cmd;
  reg [6:0] input_closed;
  reg [2:0] output_closed;
  reg [31:0] seed, rsp, a, b, imm, acc, want;
  reg [7:0] mask;
  integer err_total, comparisons, i, k;
  wire cmd_valid, cmd_sel_a_numeric, cmd_sel_b_numeric, rsp_valid;
  wire jump_valid, jump_taken;
  wire [3:0] cmd_op;
  wire [9:0] cmd_sel_a, cmd_sel_b;
  wire [31:0] cmd_data, rsp_data;
  wire [7:0] condition_out;
  data_register_math_condition_unit dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_sel_a(cmd_sel_a), .cmd_sel_b(cmd_sel_b),
    .cmd_sel_a_numeric(cmd_sel_a_numeric), .cmd_data(cmd_data),
    .cmd_sel_b_numeric(cmd_sel_b_numeric), .adc_code(adc_code),
    .queue_line(~current_cmd), .current_cmd(current_cmd),
    .fault_code({current_cmd, ~current_cmd}), .motor_step(motor_step),
    .motor_dir(1'b0), .move_start(move_start), .move_end(move_end),
    .encoder_step(encoder_step), .encoder_dir(1'b0),
    .sensor_hit(sensor_hit), .index_closed(index_closed),
    .input_closed(input_closed), .output_closed(output_closed),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .jump_valid(jump_valid),
    .jump_taken(jump_taken), .condition_out(condition_out));
  host_cmd_model host (
    .ref_clk(ref_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel_a(cmd_sel_a),
    .cmd_sel_a_numeric(cmd_sel_a_numeric), .cmd_sel_b(cmd_sel_b),
    .cmd_sel_b_numeric(cmd_sel_b_numeric), .cmd_data(cmd_data));
  always #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  function [31:0] rnd(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      rnd = x ^ (x << 5);
    end
  endfunction
  // Multiply and divide work on signed low halves
  function [31:0] exp_math(input [3:0] o, input [31:0] x, input [31:0] y);
    case (o)
      `OP_ADD: exp_math = x + y;
      `OP_SUB: exp_math = x - y;
      `OP_MUL: exp_math = $signed(x[15:0]) * $signed(y[15:0]);
      `OP_DIV: exp_math = $signed(x[15:0]) / $signed(y[15:0]);
      `OP_AND: exp_math = x & y;
      default: exp_math = x | y;
    endcase
  endfunction
  function [31:0] flags(input [31:0] x, input [31:0] y);
    begin
      flags = 32'h0;
      flags[7:6] = {x != y, x == y};
      flags[5:4] = {$signed(x) < $signed(y), $signed(x) > $signed(y)};
      flags[3:2] = {$signed(x) < 0, $signed(x) > 0};
      flags[1:0] = {x == 0, x != 0};
    end
  endfunction
  task check(input [79:0] what, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task op(input [3:0] o, input [10:0] x, input [10:0] y, input [31:0] d);
    begin
      host.send(o, x, y, d, rsp, ok);
      if (ok !== 1'b1) begin
        err_total = err_total + 1;
        final_report;
      end
    end
  endtask
  // Bits: move end, move start, sensor, encoder step, motor step
  task strobe(input [4:0] s, input integer n);
    repeat (n) begin
      @(negedge ref_clk);
      {move_end, move_start, sensor_hit, encoder_step, motor_step} = s;
      @(negedge ref_clk);
      {move_end, move_start, sensor_hit, encoder_step, motor_step} = 5'h00;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {move_end, move_start, sensor_hit, encoder_step, motor_step} = 5'h00;
    {index_closed, input_closed, output_closed} = 11'h000;
    adc_code = 16'h0000;
    current_cmd = 16'h0000;
    err_total = 0;
    comparisons = 0;
    seed = 32'h0000a031;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    strobe(5'h04, 1);
    op(`OP_READ, 11'h067, ACC, 0);
    check("sensor0", rsp, 32'h0);
    strobe(5'h08, 1);
    strobe(5'h01, 5);
    op(`OP_READ, 11'h064, ACC, 0);
    check("distance", rsp, 32'h5);
    strobe(5'h04, 1);
    op(`OP_READ, 11'h067, ACC, 0);
    check("sensor", rsp, 32'h5);
    strobe(5'h10, 1);
    strobe(5'h02, 3);
    op(`OP_READ, 11'h065, ACC, 0);
    check("encoder", rsp, 32'h3);
    op(`OP_ENC_SET, ACC, ACC, 0);
    op(`OP_READ, {1'b1, `IDX_ENCODER}, ACC, 0);
    check("enc_clear", rsp, 32'h0);
    seed = rnd(seed);
    current_cmd = seed[15:0];
    adc_code = 16'h8000;
    {index_closed, input_closed, output_closed} = seed[26:16];
    op(`OP_LOAD, {1'b1, `IDX_CURRENT}, ACC, seed);
    check("ro_load", rsp, 32'h0);
    op(`OP_READ, 11'h063, ACC, 0);
    check("current", rsp, {{16{seed[15]}}, seed[15:0]});
    op(`OP_READ, 11'h062, ACC, 0);
    check("line", rsp, {{16{~seed[15]}}, ~seed[15:0]});
    op(`OP_READ, 11'h066, ACC, 0);
    check("fault", rsp, {seed[15:0], ~seed[15:0]});
    op(4'hf, ACC, ACC, seed);
    check("bad_op", rsp, 32'h0);
    op(`OP_READ, 11'h061, ACC, 0);
    check("analog", rsp, 32'hffff8008);
    op(`OP_ANA_OFS, ACC, ACC, 32'h00000008);
    op(`OP_READ, 11'h061, ACC, 0);
    check("analog_ofs", rsp, 32'hffff8000);
    want = {21'h0, output_closed, ~input_closed, ~index_closed};
    op(`OP_READ, {1'b1, `IDX_INPUTS}, ACC, 0);
    check("inputs", rsp, want);
    acc = 32'h0;
    for (i = 0; i < 12; i = i + 1) begin
      seed = rnd(seed);
      a = (i == 1) ? 32'h0 : (i == 2) ? 32'h5 : seed;
      seed = rnd(seed);
      b = (i == 0) ? 32'h0 : seed;
      imm = (i == 0) ? a : (i == 2) ? 32'h2 : seed ^ 32'h00ff00ff;
      mask = seed[7:0];
      op(`OP_LOAD, R1, ACC, a);
      op(`OP_LOAD, R2N, ACC, b);
      for (k = `OP_ADD; k <= `OP_OR; k = k + 1) begin
        // A zero divisor leaves the accumulator alone
        if (k != `OP_DIV || b[15:0] != 16'h0)
          acc = exp_math(k[3:0], a, b);
        op(k[3:0], R1, R2N, 0);
        check("result", rsp, acc);
        op(`OP_READ, ACC, ACC, 0);
        check("accum", rsp, acc);
      end
      op(`OP_TEST_IMM, R1, ACC, imm);
      check("test", rsp, flags(a, imm));
      op(`OP_COMPARE, R1, R2N, 0);
      check("compare", rsp, flags(a, b));
      want = flags(a, b);
      op(`OP_JUMP, ACC, ACC, {24'h0, mask});
      check("jump", jump_taken, |(want[7:0] & mask));
      check("cond_out", {24'h0, condition_out}, want);
      op(`OP_READ, 11'h068, ACC, 0);
      check("cond_reg", rsp, want);
    end
    // Mid-run reset: outputs clear at once, position and user file restart
    @(negedge ref_clk);
    rst_n = 1'b0;
    @(negedge ref_clk);
    check("rst_rsp", rsp_data, 32'h0);
    check("rst_cond", {24'h0, condition_out}, 32'h0);
    check("rst_jump", jump_taken, 32'h0);
    rst_n = 1'b1;
    strobe(5'h04, 1);
    op(`OP_READ, 11'h067, ACC, 0);
    check("rst_pos", rsp, 32'h0);
    op(`OP_READ, ACC, ACC, 0);
    check("rst_acc", rsp, 32'h0);
    final_report;
  end
endmodule // data_register_math_condition_unit_tb

// File: host_cmd_model.sv
// Host model that issues register commands and collects answers
`timescale 1ns/10ps
module host_cmd_model (
  input wire ref_clk,
  input wire rsp_valid,
  input wire [31:0] rsp_data,
  output reg cmd_valid,
  output reg [3:0] cmd_op,
  output reg [9:0] cmd_sel_a,
  output reg cmd_sel_a_numeric,
  output reg [9:0] cmd_sel_b,
  output reg cmd_sel_b_numeric,
  output reg [31:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    {cmd_sel_a_numeric, cmd_sel_a} = 11'h000;
    {cmd_sel_b_numeric, cmd_sel_b} = 11'h000;
    cmd_data = 32'h00000000;
  end
  ////////////////////////////////////////
  // Select bit 10 high means numeric index, low means character code
  task send(input [3:0] op, input [10:0] a, input [10:0] b,
    input [31:0] d, output [31:0] rsp, output ok);
    integer n;
    begin
      ok = 1'b0;
      rsp = 32'h0;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      {cmd_sel_a_numeric, cmd_sel_a} = a;
      {cmd_sel_b_numeric, cmd_sel_b} = b;
      cmd_data = d;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        // Stale data must not look valid after the take
        cmd_data = ~d;
        if (rsp_valid === 1'b1) begin
          rsp = rsp_data;
          ok = 1'b1;
        end
      end
    end
  endtask
endmodule // host_cmd_model

// File: math_unit.v
// Integer arithmetic and logic unit, one operation at a time
`timescale 1ns/10ps
module math_unit (
  op,
  a,
  b,
  result,
  valid
);
  input wire [3:0] op;
  input wire [31:0] a;
  input wire [31:0] b;
  output reg [31:0] result;
  output reg valid;
`include "data_register_map.vh"

  wire signed [15:0] a_h;
  wire signed [15:0] b_h;
  wire signed [31:0] prod;
  wire signed [15:0] quot;

  assign a_h = a[15:0];
  assign b_h = b[15:0];
  // Multiply and divide keep to 16-bit operands to bound the logic
  assign prod = a_h * b_h;
  assign quot = (b_h == 16'sh0000) ? 16'sh0000 : a_h / b_h;

  always @* begin
    result = 32'h00000000;
    valid = 1'b1;
    case (op)
      `OP_ADD: result = a + b;
      `OP_SUB: result = a - b;
      `OP_MUL: result = prod;
      `OP_DIV: begin
        result = {{16{quot[15]}}, quot};
        valid = (b_h != 16'sh0000);
      end
      `OP_AND: result = a & b;
      `OP_OR: result = a | b;
      default: valid = 1'b0;
    endcase
  end
endmodule // math_unit

// File: unit_props.sv
// Port checker for the math and condition unit
`timescale 1ns/10ps
`include "data_register_map.vh"
module unit_props (
  input wire ref_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [3:0] cmd_op,
  input wire [9:0] cmd_sel_a,
  input wire cmd_sel_a_numeric,
  input wire [31:0] cmd_data,
  input wire encoder_step,
  input wire index_closed,
  input wire [6:0] input_closed,
  input wire [2:0] output_closed,
  input wire rsp_valid,
  input wire [31:0] rsp_data,
  input wire jump_valid,
  input wire jump_taken,
  input wire [7:0] condition_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire go = cmd_valid && cmd_sel_a_numeric;
  wire test = cmd_valid && (cmd_op == `OP_TEST_IMM || cmd_op == `OP_COMPARE);
  wire ro = cmd_sel_a >= `IDX_ANALOG && cmd_sel_a <= `IDX_INPUTS;
  ////////////////////////////////////////
  a_rsp_follows: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer after command");
  a_rsp_caused: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  a_flag_pairs: assert property (test |=> rsp_data[0] != rsp_data[1]
    && rsp_data[6] != rsp_data[7] && rsp_data[2] + rsp_data[3] < 2)
    else $error("condition flag pairs inconsistent");
  a_order_onehot: assert property (test |=> $onehot(rsp_data[6:4]))
    else $error("greater less equal not exclusive");
  a_cond_update: assert property (test ##1 1'b1
    |=> condition_out == $past(rsp_data[7:0]))
    else $error("condition word not replaced");
  a_jump_mask: assert property (cmd_valid && cmd_op == `OP_JUMP
    |=> jump_valid && jump_taken == |(condition_out & $past(cmd_data[7:0])))
    else $error("jump decision wrong");
  a_jump_caused: assert property (jump_valid
    |-> $past(cmd_valid && cmd_op == `OP_JUMP))
    else $error("jump without command");
  a_ro_ignored: assert property (go && cmd_op == `OP_LOAD && ro
    |=> rsp_data == 32'h0)
    else $error("read-only load answered nonzero");
  a_input_map: assert property (go && cmd_op == `OP_READ
    && cmd_sel_a == `IDX_INPUTS && $stable(input_closed)
    && $stable(output_closed) && $stable(index_closed)
    |=> rsp_data == {21'h0, $past(output_closed), ~$past(input_closed),
    ~$past(index_closed)})
    else $error("input pattern wrong");
  a_enc_clear: assert property (cmd_valid && cmd_op == `OP_ENC_SET
    && cmd_data == 32'h0 ##1 !encoder_step ##1 go && cmd_op == `OP_READ
    && cmd_sel_a == `IDX_ENCODER |=> rsp_data == 32'h0)
    else $error("encoder not cleared");
endmodule // unit_props
